//--- vcsp_serial_port.sv
// serial port and configuration register of a voiceband codec
`timescale 1ns/100ps
`default_nettype none

module vcsp_serial_port #(
    parameter int FRAME_BITS = vcsp_pkg::FRAME_BITS_C
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic chipEnable,
    input wire logic inFrameSync,
    input wire logic serialIn,
    input wire logic wordTypeSelect,
    input wire logic [15:0] txSample,
    output logic txSampleTake,
    output logic [15:0] rxSample,
    output logic rxSampleValid,
    output var vcsp_pkg::vcsp_cfg_t codecConfig,
    output logic bitClk,
    output logic serialOut,
    output logic outFrameSync,
    output logic outEnN
);
    import vcsp_pkg::*;

    // ----------------------------------------------------------------
    // reset release and pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] rstPipe_r;
    logic rstnQ;
    logic [3:0] pinMeta_r;
    logic [3:0] pinSync_r;
    logic ceS, fsS, sdiS, wtsS;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rstPipe_r <= 2'b00;
        end else begin
            rstPipe_r <= {rstPipe_r[0], 1'b1};
        end
    end
    assign rstnQ = rstPipe_r[1];

    always_ff @(posedge core_clk or negedge rstnQ) begin
        if (!rstnQ) begin
            pinMeta_r <= 4'h0;
            pinSync_r <= 4'h0;
        end else begin
            pinMeta_r <= {chipEnable, inFrameSync, serialIn, wordTypeSelect};
            pinSync_r <= pinMeta_r;
        end
    end
    assign ceS = pinSync_r[3];
    assign fsS = pinSync_r[2];
    assign sdiS = pinSync_r[1];
    assign wtsS = pinSync_r[0];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstnQ);

    // ----------------------------------------------------------------
    // bit clock divider
    // ----------------------------------------------------------------
    logic [2:0] div_r;
    logic [2:0] divNxt;
    logic bitTick;
    logic bitClk_r;

    assign bitTick = (div_r == DIV_LAST);
    assign divNxt = bitTick ? 3'h0 : div_r + 3'h1;

    always_ff @(posedge core_clk or negedge rstnQ) begin
        if (!rstnQ) begin
            // parked on the last count so the first clock pulse is full width
            div_r <= DIV_LAST;
            bitClk_r <= 1'b0;
        end else begin
            div_r <= divNxt;
            bitClk_r <= (divNxt < DIV_HIGH);
        end
    end
    assign bitClk = bitClk_r;

    a_bit_clock_div: assert property ($rose(bitClk) |=>
        bitClk ##1 !bitClk[*3] ##1 $rose(bitClk))
        else $error("bit clock period is not five core cycles");

    // ----------------------------------------------------------------
    // receive shifter
    // ----------------------------------------------------------------
    // inputs are sampled at the end of each bit cycle, which covers the
    // falling edge plus the two-flop synchroniser delay
    logic rxActive_r;
    logic [3:0] rxCnt_r;
    logic [15:0] rxShift_r;
    logic rxType_r;
    logic [15:0] rxWord;
    logic wordDone;

    assign rxWord = {rxShift_r[14:0], sdiS};
    assign wordDone = bitTick && rxActive_r && (rxCnt_r == RX_LAST);

    always_ff @(posedge core_clk or negedge rstnQ) begin
        if (!rstnQ) begin
            rxActive_r <= 1'b0;
            rxCnt_r <= 4'h0;
            rxShift_r <= 16'h0000;
            rxType_r <= 1'b0;
        end else if (!ceS) begin
            rxActive_r <= 1'b0;
        end else if (bitTick) begin
            if (rxActive_r) begin
                rxShift_r <= rxWord;
                rxCnt_r <= rxCnt_r + 4'h1;
            end
            // sync seen only when idle or in the last bit cycle
            if (!rxActive_r || rxCnt_r == RX_LAST) begin
                // word begins on the bit cycle after the sync
                rxActive_r <= fsS;
                rxCnt_r <= 4'h0;
                if (fsS) begin
                    rxType_r <= wtsS;
                end
            end
        end
    end

    a_rx_ignore_sync: assert property (bitTick && ceS && rxActive_r &&
        rxCnt_r != RX_LAST |=> rxActive_r && rxCnt_r == $past(rxCnt_r) + 4'h1)
        else $error("input word disturbed before its last bit");

    // ----------------------------------------------------------------
    // word decode and configuration register
    // ----------------------------------------------------------------
    logic isData, isCtrl, cfgWrite, readReq, readRdy;
    vcsp_cfg_t cfg_r;
    logic powered;

    assign isData = wordDone && rxType_r;
    assign isCtrl = wordDone && !rxType_r;
    assign cfgWrite = isCtrl && !rxWord[CFG_MSB];
    // msb one is never written; only READ_REQ and READ_RDY act as read words
    assign readReq = isCtrl && (rxWord == READ_REQ);
    assign readRdy = isCtrl && (rxWord == READ_RDY);

    always_ff @(posedge core_clk or negedge rstnQ) begin
        if (!rstnQ) begin
            cfg_r <= CFG_RESET;
        end else if (cfgWrite) begin
            // whole word copied; reserved bits are the host's duty
            cfg_r <= rxWord;
        end
    end

    always_ff @(posedge core_clk or negedge rstnQ) begin
        if (!rstnQ) begin
            rxSample <= 16'h0000;
            rxSampleValid <= 1'b0;
        end else begin
            rxSampleValid <= isData;
            if (isData) begin
                rxSample <= rxWord;
            end
        end
    end

    // preamp, input mux, filter bypass, gain code
    // power controls drive the analog sections straight from the bits
    assign codecConfig = cfg_r;
    assign powered = cfg_r.analogPowerOn && cfg_r.digitalPowerOn;

    a_cfg_write_only: assert property (!$stable(cfg_r) |->
        $past(wordDone) && !$past(rxType_r) && !$past(rxWord[CFG_MSB]))
        else $error("configuration changed without a write word");

    a_read_keeps_cfg: assert property (readReq || readRdy |=>
        $stable(cfg_r))
        else $error("read word altered the configuration");

    // ----------------------------------------------------------------
    // read-back handshake
    // ----------------------------------------------------------------
    logic readPend_r;
    logic readyPend_r;
    logic cfgStart;

    always_ff @(posedge core_clk or negedge rstnQ) begin
        if (!rstnQ) begin
            readPend_r <= 1'b0;
            readyPend_r <= 1'b0;
        end else begin
            // hold sample frames until the read-back word is launched
            if (readReq) begin
                readPend_r <= 1'b1;
            end else if (cfgStart) begin
                readPend_r <= 1'b0;
            end
            if (readRdy && readPend_r) begin
                readyPend_r <= 1'b1;
            end else if (cfgStart) begin
                readyPend_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // frame scheduler
    // ----------------------------------------------------------------
    vcsp_mode_t mode_r;
    logic [CNT_W-1:0] cnt_r;
    logic shActive_r;
    logic sampleStart;
    logic startWord;

    // read ready launches the register word once the line is free
    assign cfgStart = bitTick && ceS && powered && readyPend_r &&
        !shActive_r;
    // one word per frame, none while a read is pending
    assign sampleStart = bitTick && ceS && (mode_r == MODE_RUN) &&
        (cnt_r == '0) && !readPend_r && !shActive_r;
    assign startWord = sampleStart || cfgStart;
    assign txSampleTake = sampleStart;

    always_ff @(posedge core_clk or negedge rstnQ) begin
        if (!rstnQ) begin
            mode_r <= MODE_OFF;
            cnt_r <= '0;
        end else if (!powered) begin
            mode_r <= MODE_OFF;
            cnt_r <= CNT_W'(STARTUP_BITS - 1);
        end else if (bitTick) begin
            unique case (mode_r)
                MODE_OFF: begin
                    // start-up delay begins after the write
                    mode_r <= MODE_START;
                end
                MODE_START: begin
                    if (cnt_r == '0) begin
                        mode_r <= MODE_RUN;
                    end else begin
                        cnt_r <= cnt_r - CNT_W'(1);
                    end
                end
                MODE_RUN: begin
                    if (startWord) begin
                        cnt_r <= CNT_W'(FRAME_BITS - 1);
                    end else if (cnt_r != '0) begin
                        cnt_r <= cnt_r - CNT_W'(1);
                    end
                end
                default: begin
                    mode_r <= MODE_OFF;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // transmit shifter
    // ----------------------------------------------------------------
    logic [4:0] shCnt_r;
    logic [15:0] shWord_r;
    logic fs_r, sdo_r, outEnN_r;

    always_ff @(posedge core_clk or negedge rstnQ) begin
        if (!rstnQ) begin
            shActive_r <= 1'b0;
            shCnt_r <= 5'h00;
            shWord_r <= 16'h0000;
            fs_r <= 1'b0;
            sdo_r <= 1'b0;
        end else if (!ceS || !powered) begin
            // sync low; data line keeps its last value
            shActive_r <= 1'b0;
            fs_r <= 1'b0;
        end else if (bitTick) begin
            if (startWord) begin
                // read-back framed like a sample word
                shActive_r <= 1'b1;
                shCnt_r <= 5'h00;
                shWord_r <= cfgStart ? cfg_r : txSample;
                fs_r <= 1'b1;
            end else if (shActive_r) begin
                // data starts one bit cycle after the sync
                fs_r <= 1'b0;
                if (shCnt_r == TX_LAST) begin
                    shActive_r <= 1'b0;
                end else begin
                    sdo_r <= shWord_r[15];
                    shWord_r <= {shWord_r[14:0], 1'b0};
                    shCnt_r <= shCnt_r + 5'h01;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstnQ) begin
        if (!rstnQ) begin
            outEnN_r <= 1'b1;
        end else begin
            outEnN_r <= !ceS;
        end
    end

    assign outFrameSync = fs_r;
    assign serialOut = sdo_r;
    assign outEnN = outEnN_r;

    a_sync_one_bit: assert property ($rose(outFrameSync) |=>
        outFrameSync[*4] ##1 !outFrameSync)
        else $error("output sync not one bit cycle wide");
    a_sync_off_pwrdn: assert property (!powered |=>
        !outFrameSync)
        else $error("output sync raised in powerdown");
    a_startup_quiet: assert property ($rose(powered) |->
        !outFrameSync[*8])
        else $error("sync raised without start-up interval");
    a_frame_timer: assert property ($rose(outFrameSync) |->
        $past(cnt_r) == '0 || $past(readyPend_r))
        else $error("sample word sent before its frame slot");
    a_readback_value: assert property (cfgStart |=>
        shWord_r == $past(cfg_r) && outFrameSync)
        else $error("read-back word is not the configuration");
    a_ce_tristate: assert property (!ceS |=> outEnN)
        else $error("outputs driven while chip enable is low");

endmodule

`default_nettype wire

//--- vcsp_pkg.sv
// constants and types shared by the codec serial port
package vcsp_pkg;

    // ----------------------------------------------------------------
    // serial word and clocking
    // ----------------------------------------------------------------
    localparam int WORD_BITS = 16;
    localparam int CLK_NS = 4;
    localparam int BIT_DIV = 5;
    localparam int BIT_NS = CLK_NS * BIT_DIV;
    localparam logic [2:0] DIV_LAST = 3'h4;
    localparam logic [2:0] DIV_HIGH = 3'h2;
    localparam logic [3:0] RX_LAST = 4'hf;
    localparam logic [4:0] TX_LAST = 5'h10;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int FRAME_NS = 125000;
    localparam int FRAME_BITS_C = FRAME_NS / BIT_NS;
    localparam int STARTUP_NS = 2000;
    localparam int STARTUP_BITS = (STARTUP_NS + BIT_NS - 1) / BIT_NS;
    localparam int CNT_W = 13;

    // ----------------------------------------------------------------
    // configuration register and control words
    // ----------------------------------------------------------------
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [15:0] READ_REQ = 16'h8000;
    localparam logic [15:0] READ_RDY = 16'hc000;
    localparam int CFG_MSB = 15;

    typedef struct packed {
        logic [5:0] reserved;
        logic [2:0] outGainCode;
        logic spare;
        logic digitalPowerOn;
        logic analogPowerOn;
        logic adcHpfBypass;
        logic dacHpfBypass;
        logic inputMuxSelect;
        logic preampSelect;
    } vcsp_cfg_t;

    typedef enum logic [2:0] {
        MODE_OFF = 3'b001,
        MODE_START = 3'b010,
        MODE_RUN = 3'b100
    } vcsp_mode_t;

endpackage

//--- vcsp_host_model.sv
// host processor model: drives the input link, collects output words
`timescale 1ns/100ps
`default_nettype none

module vcsp_host_model (
    input wire logic bitClk,
    input wire logic serialOut,
    input wire logic outFrameSync,
    output logic inFrameSync,
    output logic serialIn,
    output logic wordTypeSelect
);
    logic [15:0] rxWord;
    logic [15:0] words[$];
    realtime syncAt[$];
    int bitIdx;

    initial begin
        inFrameSync = 1'b0;
        serialIn = 1'b0;
        wordTypeSelect = 1'b0;
        rxWord = 16'h0000;
        bitIdx = -1;
    end

    // ----------------------------------------------------------------
    // input link
    // ----------------------------------------------------------------
    // sync, type, msb first
    // one or two words back to back (second sync in the 16th bit cycle);
    // glitch raises the sync once more inside the word
    task automatic send(input logic isData, input logic [31:0] w,
                        input int n, input int glitch);
        for (int c = 0; c <= 16 * n; c++) begin
            @(posedge bitClk);
            #2;
            inFrameSync = (c == 0) || (c == 16 && n == 2) || (c == glitch);
            wordTypeSelect = isData;
            serialIn = (c == 0) ? ~serialIn : w[32 - c];
        end
        @(posedge bitClk);
        #2;
        inFrameSync = 1'b0;
        // released data line must not keep the last bit
        serialIn = ~serialIn;
    endtask

    // ----------------------------------------------------------------
    // output link
    // ----------------------------------------------------------------
    // data bits follow the sync cycle, msb first
    always @(negedge bitClk) begin
        if (bitIdx >= 0) begin
            rxWord[bitIdx[3:0]] = serialOut;
            if (bitIdx == 0) begin
                words.push_back(rxWord);
            end
            bitIdx--;
        end else if (outFrameSync) begin
            syncAt.push_back($realtime);
            bitIdx = 15;
        end
    end
endmodule

`default_nettype wire

//--- voiceband_codec_serial_port_test.sv
// self-checking bench for the codec serial port
`timescale 1ns/100ps
`default_nettype none

module voiceband_codec_serial_port_test;
    import vcsp_pkg::*;

    localparam int FB = 40;
    logic core_clk, rstn, chipEnable, txSampleTake, rxSampleValid;
    logic bitClk, serialOut, outFrameSync, outEnN;
    logic inFrameSync, serialIn, wordTypeSelect, prevB;
    logic [15:0] txSample, rxSample, w;
    vcsp_cfg_t codecConfig;
    wire logic clkPin, fsPin, dataPin;
    int bad_count, cmp_count, rxCount, takeCount, n, n1;
    realtime tEnd;

    vcsp_serial_port #(.FRAME_BITS(FB)) dut (.core_clk(core_clk),
        .rstn(rstn), .chipEnable(chipEnable), .inFrameSync(inFrameSync),
        .serialIn(serialIn), .wordTypeSelect(wordTypeSelect),
        .txSample(txSample), .txSampleTake(txSampleTake),
        .rxSample(rxSample), .rxSampleValid(rxSampleValid),
        .codecConfig(codecConfig), .bitClk(bitClk),
        .serialOut(serialOut), .outFrameSync(outFrameSync),
        .outEnN(outEnN));

    // released pins: clock and sync pulled low, data shows no stale bit
    assign clkPin = outEnN ? 1'b0 : bitClk;
    assign fsPin = outEnN ? 1'b0 : outFrameSync;
    assign dataPin = outEnN ? ~serialOut : serialOut;

    vcsp_host_model host (.bitClk(clkPin), .serialOut(dataPin),
        .outFrameSync(fsPin), .inFrameSync(inFrameSync),
        .serialIn(serialIn), .wordTypeSelect(wordTypeSelect));

    always #2 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        if (rxSampleValid === 1'b1) begin
            rxCount++;
        end
        if (txSampleTake === 1'b1) begin
            takeCount++;
        end
    end

    // ----------------------------------------------------------------
    // checks and report
    // ----------------------------------------------------------------
    task automatic fail(input string msg);
        bad_count++;
        $display("[ERR] %0t %s", $time, msg);
    endtask

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check_val(input logic [15:0] got, input logic [15:0] e);
        cmp_count++;
        if (got !== e) fail($sformatf("got %h expected %h", got, e));
    endtask

    task automatic check_time(input realtime got, input realtime lo,
                              input realtime hi);
        cmp_count++;
        if (got < lo || got > hi) fail($sformatf("interval %0t", got));
    endtask

    task automatic wait_words(input int cnt);
        int k;
        k = 0;
        while (host.words.size() < cnt && k < 2000) begin
            @(negedge core_clk);
            k++;
        end
        if (k == 2000) begin
            fail("no output word");
            tally_and_finish();
        end
    endtask

    task automatic write_word(input logic isData, input logic [15:0] v);
        host.send(isData, {v, 16'h0000}, 1, -1);
        repeat (2) @(negedge core_clk);
    endtask

    initial begin
        repeat (60000) @(posedge core_clk);
        fail("run too long");
        tally_and_finish();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        rstn = 1'b0;
        chipEnable = 1'b1;
        txSample = 16'hb38d;
        bad_count = 0;
        cmp_count = 0;
        rxCount = 0;
        takeCount = 0;
        repeat (2) @(negedge core_clk);
        rstn = 1'b1;
        repeat (20) @(negedge core_clk);
        check_val(codecConfig, CFG_RESET);
        n = 0;
        prevB = bitClk;
        repeat (100) begin
            @(negedge core_clk);
            if (bitClk === 1'b1 && prevB === 1'b0) n++;
            prevB = bitClk;
        end
        check_val(n[15:0], 16'h0014);
        $display("test reset done");

        // field patterns with at most one power bit set
        for (int g = 0; g < 8; g++) begin
            w = {6'h00, g[2:0], 1'b0, g[0], ~g[0], g[2:1] ^ 2'h1, g[1:0]};
            write_word(1'b0, w);
            check_val(codecConfig, w);
        end
        repeat (3 * FB * BIT_DIV) @(negedge core_clk);
        n = host.syncAt.size();
        check_val(n[15:0], 16'h0000);
        $display("test config done");

        // end of write is the bit clock rise after its last bit, plus 2 ns;
        // the host stamps the sync at the falling bit clock edge
        host.send(1'b0, {16'h0030, 16'h0000}, 1, -1);
        tEnd = $realtime;
        wait_words(1);
        txSample = 16'h4c72;
        check_time(host.syncAt[0] - tEnd, (STARTUP_BITS + 1) * BIT_NS,
                   (STARTUP_BITS + 3) * BIT_NS);
        wait_words(3);
        check_val(host.words[0], 16'hb38d);
        check_val(host.words[1], 16'h4c72);
        check_val(takeCount[15:0], 16'h0003);
        check_time(host.syncAt[2] - host.syncAt[1], FB * BIT_NS,
                   FB * BIT_NS);
        $display("test output done");

        host.send(1'b1, {16'h6e21, 16'h0000}, 1, -1);
        repeat (2) @(negedge core_clk);
        check_val(rxSample, 16'h6e21);
        host.send(1'b1, {16'h9a17, 16'h53e8}, 2, -1);
        repeat (2) @(negedge core_clk);
        check_val(rxSample, 16'h53e8);
        host.send(1'b1, {16'h0ff0, 16'h0000}, 1, 6);
        repeat (2) @(negedge core_clk);
        check_val(rxSample, 16'h0ff0);
        check_val(rxCount[15:0], 16'h0004);
        $display("test input done");

        write_word(1'b0, READ_REQ);
        check_val(codecConfig, 16'h0030);
        n = host.words.size();
        repeat (3 * FB * BIT_DIV) @(negedge core_clk);
        n1 = host.words.size() - n;
        check_val(n1 > 1, 1'b0);
        n1 = host.words.size();
        write_word(1'b0, READ_RDY);
        wait_words(n1 + 1);
        check_val(host.words[n1], 16'h0030);
        wait_words(n1 + 2);
        check_val(host.words[n1 + 1], 16'h4c72);
        check_time(host.syncAt[n1 + 1] - host.syncAt[n1], 17 * BIT_NS,
                   (FB + 1) * BIT_NS);
        $display("test readback done");

        chipEnable = 1'b0;
        repeat (10) @(negedge core_clk);
        check_val(outEnN, 1'b1);
        n = 0;
        repeat (3 * FB * BIT_DIV) begin
            @(negedge core_clk);
            if (outFrameSync !== 1'b0) n++;
        end
        check_val(n[15:0], 16'h0000);
        chipEnable = 1'b1;
        n1 = host.words.size();
        wait_words(n1 + 1);
        check_val(outEnN, 1'b0);
        check_val(host.words[n1], 16'h4c72);
        $display("test enable done");
        tally_and_finish();
    end
endmodule

`default_nettype wire
